/* awt_pkg.sv */
/*
 * Shared constants and types for the alarm window threshold registers.
 * Assumes a 16-bit register word and a 12-bit two's-complement
 * temperature result in 0.125 degree steps.
 */
package awt_pkg;
    localparam int          REG_W        = 16;
    localparam int          SIGN_BIT     = 12;
    localparam int          VAL_LSB      = 2;
    localparam int          ABOVE_BIT    = 14;
    localparam int          BELOW_BIT    = 13;
    localparam int          TEMP_W       = 12;
    localparam logic [15:0] THR_RESET    = 16'h0000;
    localparam logic [15:0] THR_WR_MASK  = 16'h1FFC;
    localparam logic        SEL_UPPER    = 1'b0;
    localparam logic        SEL_LOWER    = 1'b1;

    // One register access from the management bus front end
    typedef struct packed {
        logic        sel;
        logic        wr;
        logic        rd;
        logic [15:0] wdata;
    } awt_req_t;
endpackage

/* awt_regs.sv */
/*
 * Upper and lower alarm window threshold registers with window compare.
 * Assumes the serial bus front end and the converter run on clk and
 * present one-cycle strobes: req.wr, req.rd and temp_valid.
 */
`timescale 1ns/1ns
// Overview of operation
// - Upper threshold: 16 bits, sign bit 12, magnitude 11:2, quarter degree.
// - Lower threshold: separate register, same layout as upper.
// - Thresholds are two's complement, bit 2 weighs 0.25 degree.
// - Bits 15:13 and 1:0 of both registers always read zero.
// - Bits 12:2 are writable and read back; reserved bits read-only.
// - Compares use the thresholds held now; new writes apply from the next cycle.
// - Lower threshold is the bottom edge of the alarm window.
// - Upper threshold is the top edge of the alarm window.
// - Above-window flag set when temperature exceeds upper, else cleared.
// - Below-window flag set when temperature is below lower, else cleared.
module awt_regs
    import awt_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     arst_n,
    input  wire awt_req_t                 req,
    input  wire logic signed [TEMP_W-1:0] temp_value,
    input  wire logic                     temp_valid,
    output logic [REG_W-1:0]              rd_data,
    output logic                          rd_valid,
    output logic [REG_W-1:0]              upper_threshold_value,
    output logic [REG_W-1:0]              lower_threshold_value,
    output logic                          above_window_flag,
    output logic                          below_window_flag
);
    // Threshold in the temperature's 0.125 degree scale
    function automatic logic signed [TEMP_W-1:0] to_temp_scale(
        input logic [REG_W-1:0] thr
    );
        to_temp_scale = {thr[SIGN_BIT:VAL_LSB], 1'b0};
    endfunction

    // Threshold field must fill the temperature word
    if (SIGN_BIT - VAL_LSB + 2 != TEMP_W) begin : g_bad_layout
        $error("threshold field does not fit the temperature word");
    end

    wire logic [REG_W-1:0] wr_value;
    wire logic             wr_upper;
    wire logic             wr_lower;
    wire logic [REG_W-1:0] next_rd_data;
    wire logic             next_above;
    wire logic             next_below;

    assign wr_value = req.wdata & THR_WR_MASK;
    assign wr_upper = req.wr && (req.sel == SEL_UPPER);
    assign wr_lower = req.wr && (req.sel == SEL_LOWER);
    assign next_rd_data = (req.sel == SEL_UPPER) ? upper_threshold_value
                                                 : lower_threshold_value;
    assign next_above = temp_value >
                        to_temp_scale(upper_threshold_value);
    assign next_below = temp_value <
                        to_temp_scale(lower_threshold_value);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            upper_threshold_value <= THR_RESET;
            lower_threshold_value <= THR_RESET;
        end else begin
            if (wr_upper) begin
                upper_threshold_value <= wr_value;
            end
            if (wr_lower) begin
                lower_threshold_value <= wr_value;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data  <= THR_RESET;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= req.rd;
            if (req.rd) begin
                rd_data <= next_rd_data;
            end
        end
    end

    // Compare against whatever is held now
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            above_window_flag <= 1'b0;
            below_window_flag <= 1'b0;
        end else if (temp_valid) begin
            above_window_flag <= next_above;
            below_window_flag <= next_below;
        end
    end

    // Helper: set once any write has happened since reset
    logic seen_wr;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            seen_wr <= 1'b0;
        end else if (req.wr) begin
            seen_wr <= 1'b1;
        end
    end

    sequence s_wr_upper;
        req.wr && req.sel == SEL_UPPER;
    endsequence

    sequence s_wr_then_sample;
        s_wr_upper ##1 temp_valid;
    endsequence

    sequence s_wr_lower;
        req.wr && req.sel == SEL_LOWER;
    endsequence

    sequence s_wr_lower_then_sample;
        s_wr_lower ##1 temp_valid;
    endsequence

    property p_upper_store;
        @(posedge clk) disable iff (!arst_n)
        s_wr_upper |=> upper_threshold_value ==
            ($past(req.wdata) & THR_WR_MASK);
    endproperty
    a_upper_store: assert property (p_upper_store)
        else $error("upper threshold not stored");

    property p_lower_store;
        @(posedge clk) disable iff (!arst_n)
        req.wr && req.sel == SEL_LOWER |=> lower_threshold_value ==
            ($past(req.wdata) & THR_WR_MASK);
    endproperty
    a_lower_store: assert property (p_lower_store)
        else $error("lower threshold not stored");

    property p_upper_hold;
        @(posedge clk) disable iff (!arst_n)
        !wr_upper |=> $stable(upper_threshold_value);
    endproperty
    a_upper_hold: assert property (p_upper_hold)
        else $error("upper threshold changed without a write");

    property p_lower_hold;
        @(posedge clk) disable iff (!arst_n)
        !wr_lower |=> $stable(lower_threshold_value);
    endproperty
    a_lower_hold: assert property (p_lower_hold)
        else $error("lower threshold changed without a write");

    property p_reserved_zero;
        @(posedge clk) disable iff (!arst_n)
        rd_valid |-> (rd_data & ~THR_WR_MASK) == 16'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");

    property p_readback;
        @(posedge clk) disable iff (!arst_n)
        req.rd |=> rd_valid && rd_data == ($past(req.sel) == SEL_UPPER
            ? $past(upper_threshold_value) : $past(lower_threshold_value));
    endproperty
    a_readback: assert property (p_readback)
        else $error("read data does not match register");

    property p_rd_pulse;
        @(posedge clk) disable iff (!arst_n)
        !req.rd |=> !rd_valid;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("read valid without a read");

    property p_rd_hold;
        @(posedge clk) disable iff (!arst_n)
        !req.rd |=> $stable(rd_data);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data changed without a read");

    property p_new_bound;
        @(posedge clk) disable iff (!arst_n)
        s_wr_then_sample |=> above_window_flag == ($past(temp_value) >
            to_temp_scale($past(req.wdata, 2) & THR_WR_MASK));
    endproperty
    a_new_bound: assert property (p_new_bound)
        else $error("new upper bound not used");

    property p_new_lower;
        @(posedge clk) disable iff (!arst_n)
        s_wr_lower_then_sample |=> below_window_flag == ($past(temp_value) <
            to_temp_scale($past(req.wdata, 2) & THR_WR_MASK));
    endproperty
    a_new_lower: assert property (p_new_lower)
        else $error("new lower bound not used");

    property p_above;
        @(posedge clk) disable iff (!arst_n)
        temp_valid |=> above_window_flag == ($past(temp_value) >
            to_temp_scale($past(upper_threshold_value)));
    endproperty
    a_above: assert property (p_above)
        else $error("above window flag wrong");

    property p_below;
        @(posedge clk) disable iff (!arst_n)
        temp_valid |=> below_window_flag == ($past(temp_value) <
            to_temp_scale($past(lower_threshold_value)));
    endproperty
    a_below: assert property (p_below)
        else $error("below window flag wrong");

    property p_hold_flags;
        @(posedge clk) disable iff (!arst_n)
        !temp_valid |=> $stable(above_window_flag) &&
            $stable(below_window_flag);
    endproperty
    a_hold_flags: assert property (p_hold_flags)
        else $error("flags changed without a sample");

    property p_reset_zero;
        @(posedge clk) disable iff (!arst_n)
        !seen_wr |-> upper_threshold_value == THR_RESET &&
            lower_threshold_value == THR_RESET;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("threshold not zero after reset");
endmodule

/* awt_host.sv */
/*
 * Host model issuing single threshold register accesses.
 * Assumes the bench supplies clk and calls acc after reset.
 */
`timescale 1ns/1ns
module awt_host
    import awt_pkg::*;
(
    input  wire logic clk,
    output awt_req_t  req
);
    initial req = '0;

    // One strobe cycle, then idle
    task automatic acc(input logic s, input logic w, input logic [15:0] d);
        @(posedge clk);
        req <= '{sel: s, wr: w, rd: !w, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask
endmodule

/* tb_awt_regs.sv */
/*
 * Bench for the alarm window threshold registers.
 * Assumes awt_host drives req and a 10 MHz clock.
 */
`timescale 1ns/1ns
module tb_awt_regs
    import awt_pkg::*;
;
    logic                     clk         = 1'b0;
    logic                     arst_n      = 1'b0;
    logic signed [TEMP_W-1:0] temp_value  = '0;
    logic                     temp_valid  = 1'b0;
    awt_req_t                 req;
    logic [REG_W-1:0]         rd_data;
    logic [REG_W-1:0]         upper;
    logic [REG_W-1:0]         lower;
    logic                     rd_valid;
    logic                     above;
    logic                     below;
    int                       miscompares = 0;
    int                       checks      = 0;
    int                       cycles      = 0;
    int                       tv [4]      = '{200, 201, -8, -9};
    logic [1:0]               ev [4]      = '{2'b00, 2'b10, 2'b00, 2'b01};

    awt_host host (.clk(clk), .req(req));
    awt_regs uut (.clk(clk), .arst_n(arst_n), .req(req),
        .temp_value(temp_value), .temp_valid(temp_valid),
        .rd_data(rd_data), .rd_valid(rd_valid),
        .upper_threshold_value(upper), .lower_threshold_value(lower),
        .above_window_flag(above), .below_window_flag(below));

    always #50 clk = ~clk;

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 500) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic chk(input string n, input logic [15:0] s, e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic rd(input logic s, input logic [15:0] e);
        host.acc(s, 1'b0, 16'h0000);
        #1 chk("rd_valid", {15'h0000, rd_valid}, 16'h0001);
        chk("rd_data", rd_data, e);
    endtask

    // Temperature in 0.125 degree units
    task automatic tmp(input int t, input logic [1:0] e);
        @(posedge clk);
        temp_value <= t[TEMP_W-1:0];
        temp_valid <= 1'b1;
        @(posedge clk);
        temp_valid <= 1'b0;
        #1 chk("flags", {14'h0000, above, below}, {14'h0000, e});
    endtask

    // Reset for two cycles, thresholds read zero after it
    task automatic reset_pulse();
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        #1 chk("upper", upper, THR_RESET);
        chk("lower", lower, THR_RESET);
    endtask

    // Write, then sample in the very next cycle
    task automatic wr_tmp(input logic s, input logic [15:0] d,
                          input int t, input logic [1:0] e);
        fork
            host.acc(s, 1'b1, d);
            begin
                @(posedge clk);
                tmp(t, e);
            end
        join
    endtask

    initial begin
        reset_pulse();
        host.acc(SEL_UPPER, 1'b1, 16'hFFFF);
        #1 chk("upper", upper, 16'h1FFC);
        rd(SEL_UPPER, 16'h1FFC);
        host.acc(SEL_LOWER, 1'b1, 16'hFFF3);
        host.acc(SEL_UPPER, 1'b1, 16'hE190);
        rd(SEL_LOWER, 16'h1FF0);
        rd(SEL_UPPER, 16'h0190);
        foreach (tv[i]) tmp(tv[i], ev[i]);
        host.acc(SEL_LOWER, 1'b1, 16'h0004);
        wr_tmp(SEL_UPPER, 16'h1FFC, 1, 2'b11);
        wr_tmp(SEL_LOWER, 16'h1FF8, 1, 2'b10);
        @(posedge clk);
        reset_pulse();
        rd(SEL_LOWER, 16'h0000);
        tally_and_finish();
    end
endmodule
